// *** code_map_consts.vh ***
`ifndef CODE_MAP_CONSTS_VH
`define CODE_MAP_CONSTS_VH

// register addresses on the special function register bus
`define ADDR_POWER_WRITE_CTRL  8'h87
`define ADDR_DATA_STRETCH      8'h8e
`define ADDR_CODE_WAIT_STATES  8'h92
`define ADDR_CHIP_CONFIG       8'hff

// reset values
`define RST_POWER_WRITE_CTRL   8'h00
`define RST_DATA_STRETCH       8'h07
`define RST_CODE_WAIT_STATES   8'h07
`define RST_CHIP_CONFIG        8'h00

// power_and_write_control fields
`define PWC_SERIAL_RATE_DOUBLE 7
`define PWC_PROGRAM_WRITE_EN   4
`define PWC_WRITABLE_MASK      8'hf8

// data_stretch_control fields
`define DSC_WRITABLE_MASK      8'hc7
`define DSC_PULSE_MSB          2

// code_wait_states fields
`define CWS_MSB                2

// chip_config fields
`define CFG_ROM_MAP_KEEP       7
`define CFG_ISP_ENABLE         6
`define CFG_FLASH_FULL_ENABLE  2
`define CFG_FLASH_BUSY         1
`define CFG_BOOT_STATE         0

// code memory map
`define BOOT_ROM_LAST          16'h07ff
`define ENTRY_STUB_FIRST       16'hfff7

// minimum field values: code wait states 3, data pulse field 2
`define MIN_CODE_WAIT          3'h3
`define MIN_DATA_PULSE         3'h2

// internal memory layout
`define IRAM_BANK_LAST         8'h1f
`define IRAM_BIT_AREA_FIRST    8'h20
`define IRAM_BIT_AREA_LAST     8'h2f
`define IRAM_UPPER_FIRST       8'h80
`define SFR_BIT_GROUP_MASK     8'hf8

// internal region codes
`define REGION_BANK            2'h0
`define REGION_BIT_AREA        2'h1
`define REGION_SCRATCH         2'h2
`define REGION_UPPER           2'h3

`endif

// *** code_memory_map_and_wait_control.v ***
`timescale 1ns/1ps
`include "code_map_consts.vh"

module code_memory_map_and_wait_control #(
   parameter ADDR_W = 16
) (
   input  wire              clock_i,
   input  wire              reset_i,
   input  wire              boot_select_pin_i,
   input  wire [7:0]        sfr_addr_i,
   input  wire              sfr_wr_i,
   input  wire [7:0]        sfr_wdata_i,
   output reg  [7:0]        sfr_rdata_o,
   output reg               sfr_hit_o,
   input  wire              fetch_req_i,
   input  wire [ADDR_W-1:0] fetch_addr_i,
   input  wire              movx_req_i,
   input  wire              movx_write_i,
   input  wire              movx_indexed_i,
   input  wire [ADDR_W-1:0] active_data_pointer_i,
   input  wire [7:0]        port_two_high_address_i,
   input  wire [7:0]        index_reg_i,
   input  wire [7:0]        acc_i,
   output wire              busy_o,
   output reg               done_o,
   output reg  [ADDR_W-1:0] code_addr_o,
   output reg               code_rd_o,
   output reg               code_rom_sel_o,
   output reg               code_flash_sel_o,
   output reg               code_fault_o,
   output reg               code_wr_o,
   output reg  [7:0]        code_wdata_o,
   output reg  [ADDR_W-1:0] data_addr_o,
   output reg               data_rd_o,
   output reg               data_wr_o,
   output reg  [7:0]        data_wdata_o,
   output wire              flash_in_data_o,
   input  wire [7:0]        iram_addr_i,
   input  wire              iram_indirect_i,
   output wire              iram_sfr_sel_o,
   output wire [1:0]        iram_region_o,
   output wire [2:0]        iram_bank_o,
   input  wire [7:0]        bit_addr_i,
   output wire [7:0]        bit_byte_addr_o,
   output wire [2:0]        bit_index_o
);

   localparam ST_IDLE  = 4'b0001;
   localparam ST_FETCH = 4'b0010;
   localparam ST_CWR   = 4'b0100;
   localparam ST_DATA  = 4'b1000;

   reg [7:0]        pwc_r;
   reg [7:0]        dsc_r;
   reg [7:0]        cws_r;
   reg              boot_map_r;
   reg              rom_map_keep_r;
   reg              isp_flag_r;
   reg              pin_taken_r;
   reg [3:0]        state_r;
   reg [3:0]        state_nxt;
   reg [2:0]        cnt_r;
   reg [2:0]        cnt_nxt;
   reg [ADDR_W-1:0] wr_addr;
   reg              in_rom;
   reg              in_stub;

   wire stub_mapped = boot_map_r | rom_map_keep_r;
   wire program_write_enable         = pwc_r[`PWC_PROGRAM_WRITE_EN];
   wire [2:0] code_len = clamp(cws_r[`CWS_MSB:0], `MIN_CODE_WAIT);
   wire [2:0] data_len = clamp(dsc_r[`DSC_PULSE_MSB:0], `MIN_DATA_PULSE);

   function [2:0] clamp;
      input [2:0] field;
      input [2:0] lowest;
      begin
         clamp = (field < lowest) ? lowest : field;
      end
   endfunction

   function [7:0] bit_byte;
      input [7:0] baddr;
      begin
         if (baddr < `IRAM_UPPER_FIRST) begin
            bit_byte = `IRAM_BIT_AREA_FIRST + {4'h0, baddr[6:3]};
         end else begin
            bit_byte = baddr & `SFR_BIT_GROUP_MASK;
         end
      end
   endfunction

   // code space decode for fetches and movc
   always @* begin
      in_rom  = boot_map_r && (fetch_addr_i <= `BOOT_ROM_LAST);
      in_stub = stub_mapped && (fetch_addr_i >= `ENTRY_STUB_FIRST);
   end

   // movx target address, for reads and writes
   always @* begin
      if (movx_indexed_i) begin
         wr_addr = {port_two_high_address_i, index_reg_i};
      end else begin
         wr_addr = active_data_pointer_i;
      end
   end

   // sequencer
   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_IDLE: begin
            if (fetch_req_i) begin
               state_nxt = ST_FETCH;
               cnt_nxt   = code_len;
            end else if (movx_req_i && movx_write_i && program_write_enable) begin
               state_nxt = ST_CWR;
               cnt_nxt   = data_len;
            end else if (movx_req_i) begin
               state_nxt = ST_DATA;
               cnt_nxt   = data_len;
            end
         end
         ST_FETCH, ST_CWR, ST_DATA: begin
            if (cnt_r == 3'h0) begin
               state_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cnt_nxt   = 3'h0;
         end
      endcase
   end

   assign busy_o = (state_r != ST_IDLE);

   always @(posedge clock_i) begin
      if (reset_i) begin
         state_r          <= ST_IDLE;
         cnt_r            <= 3'h0;
         done_o           <= 1'b0;
         code_addr_o      <= {ADDR_W{1'b0}};
         code_rd_o        <= 1'b0;
         code_rom_sel_o   <= 1'b0;
         code_flash_sel_o <= 1'b0;
         code_fault_o     <= 1'b0;
         code_wr_o        <= 1'b0;
         code_wdata_o     <= 8'h00;
         data_addr_o      <= {ADDR_W{1'b0}};
         data_rd_o        <= 1'b0;
         data_wr_o        <= 1'b0;
         data_wdata_o     <= 8'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         done_o  <= busy_o && (state_nxt == ST_IDLE);
         if (state_r == ST_IDLE) begin
            if (fetch_req_i) begin
               code_addr_o      <= fetch_addr_i;
               code_rd_o        <= 1'b1;
               code_rom_sel_o   <= in_rom | in_stub;
               code_flash_sel_o <= !boot_map_r && !in_stub;
               code_fault_o     <= boot_map_r && !in_rom && !in_stub;
            end else if (movx_req_i && movx_write_i && program_write_enable) begin
               code_addr_o      <= wr_addr;
               code_wr_o        <= 1'b1;
               code_wdata_o     <= acc_i;
               code_rom_sel_o   <= 1'b0;
               code_flash_sel_o <= 1'b1;
               code_fault_o     <= 1'b0;
            end else if (movx_req_i) begin
               data_addr_o  <= wr_addr;
               data_rd_o    <= !movx_write_i;
               data_wr_o    <= movx_write_i;
               data_wdata_o <= acc_i;
            end
         end else if (state_nxt == ST_IDLE) begin
            code_rd_o <= 1'b0;
            code_wr_o <= 1'b0;
            data_rd_o <= 1'b0;
            data_wr_o <= 1'b0;
         end
      end
   end

   assign flash_in_data_o = boot_map_r;

   // register file
   always @(posedge clock_i) begin
      if (reset_i) begin
         pwc_r          <= `RST_POWER_WRITE_CTRL;
         dsc_r          <= `RST_DATA_STRETCH;
         cws_r          <= `RST_CODE_WAIT_STATES;
         boot_map_r     <= 1'b1;
         rom_map_keep_r <= 1'b0;
         isp_flag_r     <= 1'b0;
         pin_taken_r    <= 1'b0;
      end else begin
         if (!pin_taken_r) begin
            isp_flag_r  <= boot_select_pin_i;
            pin_taken_r <= 1'b1;
         end
         if (sfr_wr_i) begin
            case (sfr_addr_i)
               `ADDR_POWER_WRITE_CTRL: begin
                  pwc_r <= sfr_wdata_i & `PWC_WRITABLE_MASK;
               end
               `ADDR_DATA_STRETCH: begin
                  dsc_r <= sfr_wdata_i & `DSC_WRITABLE_MASK;
               end
               `ADDR_CODE_WAIT_STATES: begin
                  cws_r <= {5'h00, sfr_wdata_i[`CWS_MSB:0]};
               end
               `ADDR_CHIP_CONFIG: begin
                  if (boot_map_r && !sfr_wdata_i[`CFG_BOOT_STATE]) begin
                     boot_map_r     <= 1'b0;
                     rom_map_keep_r <= 1'b1;
                  end else if (!boot_map_r) begin
                     rom_map_keep_r <= sfr_wdata_i[`CFG_ROM_MAP_KEEP];
                  end
               end
               default: begin
                  pwc_r <= pwc_r;
               end
            endcase
         end
      end
   end

   always @* begin
      sfr_hit_o   = 1'b1;
      sfr_rdata_o = 8'h00;
      case (sfr_addr_i)
         `ADDR_POWER_WRITE_CTRL: begin
            sfr_rdata_o = pwc_r;
         end
         `ADDR_DATA_STRETCH: begin
            sfr_rdata_o = dsc_r;
         end
         `ADDR_CODE_WAIT_STATES: begin
            sfr_rdata_o = cws_r;
         end
         `ADDR_CHIP_CONFIG: begin
            sfr_rdata_o[`CFG_ROM_MAP_KEEP]      = rom_map_keep_r;
            sfr_rdata_o[`CFG_ISP_ENABLE]        = isp_flag_r;
            sfr_rdata_o[`CFG_FLASH_FULL_ENABLE] = !stub_mapped;
            sfr_rdata_o[`CFG_FLASH_BUSY]        = code_wr_o;
            sfr_rdata_o[`CFG_BOOT_STATE]        = boot_map_r;
         end
         default: begin
            sfr_hit_o = 1'b0;
         end
      endcase
   end

   // internal memory decode
   assign iram_sfr_sel_o = (iram_addr_i >= `IRAM_UPPER_FIRST) && !iram_indirect_i;
   assign iram_region_o  = (iram_addr_i >= `IRAM_UPPER_FIRST)   ? `REGION_UPPER :
                           (iram_addr_i <= `IRAM_BANK_LAST)     ? `REGION_BANK :
                           (iram_addr_i <= `IRAM_BIT_AREA_LAST) ? `REGION_BIT_AREA :
                           `REGION_SCRATCH;
   assign iram_bank_o     = iram_addr_i[2:0];
   assign bit_byte_addr_o = bit_byte(bit_addr_i);
   assign bit_index_o     = bit_addr_i[2:0];

endmodule

// *** core_requester.sv ***
`timescale 1ns/1ps
module core_requester (
   input  wire logic clock_i,
   input  wire logic go_i,
   input  wire logic fetch_i,
   input  wire logic busy_i,
   output logic      fetch_req_o,
   output logic      movx_req_o
);
   // one request pulse per go, only while the sequencer is idle
   initial begin
      fetch_req_o = 1'b0;
      movx_req_o = 1'b0;
   end
   always @(posedge clock_i) begin
      fetch_req_o <= go_i && fetch_i && !busy_i;
      movx_req_o  <= go_i && !fetch_i && !busy_i;
   end
endmodule

// *** code_map_chk.sv ***
`timescale 1ns/1ps
module code_map_chk (
   input wire logic       clock_i,
   input wire logic       reset_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic       sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic       done_o,
   input wire logic       code_rd_o,
   input wire logic       code_flash_sel_o,
   input wire logic       code_wr_o,
   input wire logic       data_rd_o,
   input wire logic       data_wr_o,
   input wire logic       flash_in_data_o,
   input wire logic [7:0] iram_addr_i,
   input wire logic       iram_indirect_i,
   input wire logic       iram_sfr_sel_o,
   input wire logic [7:0] bit_addr_i,
   input wire logic [7:0] bit_byte_addr_o
);
   logic [2:0] ws_r, md_r;
   logic [3:0] rd_n, st_n;
   wire        st = code_wr_o | data_rd_o | data_wr_o;
   // shadow wait fields and strobe lengths
   always @(posedge clock_i) begin
      if (reset_i) begin
         ws_r <= 3'h7;
         md_r <= 3'h7;
         rd_n <= 4'h0;
         st_n <= 4'h0;
      end else begin
         if (sfr_wr_i && sfr_addr_i == 8'h92) ws_r <= sfr_wdata_i[2:0];
         if (sfr_wr_i && sfr_addr_i == 8'h8e) md_r <= sfr_wdata_i[2:0];
         rd_n <= code_rd_o ? rd_n + 4'h1 : 4'h0;
         st_n <= st ? st_n + 4'h1 : 4'h0;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_fetch_len: assert property ($fell(code_rd_o) |->
      rd_n == (ws_r < 3'h3 ? 4'h4 : {1'b0, ws_r} + 4'h1)) else $error("fetch length");
   a_fetch_min: assert property ($rose(code_rd_o) |-> code_rd_o [*4]) else $error("short fetch");
   a_data_len: assert property ($fell(st) |->
      st_n == (md_r < 3'h2 ? 4'h3 : {1'b0, md_r} + 4'h1)) else $error("strobe length");
   a_fetch_done: assert property ($fell(code_rd_o) |-> done_o) else $error("no done");
   a_pwr_zero: assert property (sfr_addr_i == 8'h87 |-> sfr_rdata_o[2:0] == 3'h0) else $error("reserved");
   a_sfr_direct: assert property (iram_sfr_sel_o == (iram_addr_i[7] && !iram_indirect_i)) else $error("sel");
   a_bit_group: assert property (bit_addr_i[7] |->
      bit_byte_addr_o == {bit_addr_i[7:3], 3'h0}) else $error("bit group");
   a_bit_area: assert property (!bit_addr_i[7] |->
      bit_byte_addr_o == 8'h20 + {4'h0, bit_addr_i[6:3]}) else $error("bit area");
   a_boot_fetch: assert property (code_rd_o && flash_in_data_o |-> !code_flash_sel_o) else $error("flash");
   a_reset_map: assert property ($past(reset_i) |-> flash_in_data_o) else $error("map");
endmodule
bind code_memory_map_and_wait_control code_map_chk u_chk (.*);

// *** code_memory_map_and_wait_control_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module code_memory_map_and_wait_control_bench;
   logic clock_i = 1'b0, reset_i = 1'b1, go = 1'b0, kind = 1'b0;
   logic boot_select_pin_i, sfr_wr_i, fetch_req_i, movx_req_i, movx_write_i, movx_indexed_i;
   logic iram_indirect_i, sfr_hit_o, busy_o, done_o, code_rd_o, code_rom_sel_o, code_flash_sel_o;
   logic code_fault_o, code_wr_o, data_rd_o, data_wr_o, flash_in_data_o, iram_sfr_sel_o;
   logic [7:0] sfr_addr_i, sfr_wdata_i, port_two_high_address_i, index_reg_i, acc_i, iram_addr_i;
   logic [7:0] bit_addr_i, sfr_rdata_o, code_wdata_o, data_wdata_o, bit_byte_addr_o;
   logic [15:0] fetch_addr_i, active_data_pointer_i, code_addr_o, data_addr_o;
   logic [1:0] iram_region_o;
   logic [2:0] iram_bank_o, bit_index_o;
   integer miscompares = 0, checks = 0, seed = 54, n, i, w;
   always #20 clock_i = ~clock_i;
   code_memory_map_and_wait_control dut (.*);
   core_requester core (.clock_i(clock_i), .go_i(go), .fetch_i(kind), .busy_i(busy_o),
      .fetch_req_o(fetch_req_i), .movx_req_o(movx_req_i));
   function integer span(input integer v, input integer lo);
      return (v < lo ? lo : v) + 1;
   endfunction
   task stop_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task sfr_wr(input [7:0] a, input [7:0] d);
      @(posedge clock_i);
      {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {a, d, 1'b1};
      @(posedge clock_i);
      sfr_wr_i <= 1'b0;
      #1;
   endtask
   task sfr_rd(input [7:0] a, input [7:0] e);
      @(posedge clock_i);
      sfr_addr_i <= a;
      #1 `CHK(sfr_rdata_o, e)
      `CHK(sfr_hit_o, a == 8'h87 || a == 8'h8e || a == 8'h92 || a == 8'hff)
   endtask
   // request through the core model, count strobe cycles up to done
   task access(input f, input [15:0] a, input integer e);
      @(posedge clock_i);
      {kind, fetch_addr_i, active_data_pointer_i, go} <= {f, a, a, 1'b1};
      @(posedge clock_i);
      go <= 1'b0;
      n = 0;
      #1;
      for (i = 0; i < 20 && done_o !== 1'b1; i++) begin
         @(posedge clock_i);
         #1 n += code_rd_o | code_wr_o | data_rd_o | data_wr_o;
      end
      `CHK(n, e)
   endtask
   initial begin
      {boot_select_pin_i, sfr_wr_i, movx_write_i, movx_indexed_i, iram_indirect_i} = '0;
      {sfr_addr_i, sfr_wdata_i, port_two_high_address_i, index_reg_i, acc_i} = '0;
      {iram_addr_i, bit_addr_i, fetch_addr_i, active_data_pointer_i} = '0;
      repeat (8) @(posedge clock_i);
      reset_i <= 1'b0;
      sfr_rd(8'h87, 8'h00);
      sfr_rd(8'h92, 8'h07);
      sfr_rd(8'h8e, 8'h07);
      sfr_rd(8'hff, 8'h01);
      sfr_rd(8'h90, 8'h00);
      for (w = 0; w < 8; w++) begin
         sfr_wr(8'h92, w[7:0]);
         sfr_wr(8'h8e, 8'h07 - w[7:0]);
         access(1'b1, 16'h0000, span(w, 3));
         `CHK(code_rom_sel_o, 1'b1)
         access(1'b0, 16'h4000, span(7 - w, 2));
         `CHK(data_addr_o, 16'h4000)
      end
      $display("wait states done");
      access(1'b1, 16'h1234, 8);
      `CHK(code_fault_o, 1'b1)
      access(1'b1, 16'hfff8, 8);
      `CHK(code_rom_sel_o, 1'b1)
      sfr_wr(8'hff, 8'h00);
      `CHK(flash_in_data_o, 1'b0)
      access(1'b1, 16'h0000, 8);
      `CHK(code_flash_sel_o, 1'b1)
      access(1'b1, 16'hfff8, 8);
      `CHK(code_rom_sel_o, 1'b1)
      sfr_wr(8'hff, 8'h00);
      access(1'b1, 16'hfff8, 8);
      `CHK(code_flash_sel_o, 1'b1)
      $display("map switch done");
      sfr_wr(8'h87, 8'hff);
      sfr_rd(8'h87, 8'hf8);
      sfr_wr(8'h8e, 8'h02);
      for (w = 0; w < 2; w++) begin
         @(posedge clock_i);
         {acc_i, port_two_high_address_i, index_reg_i} <= $random(seed);
         {movx_write_i, movx_indexed_i} <= {1'b1, w[0]};
         access(1'b0, 16'hbeef, 3);
         `CHK(code_wdata_o, acc_i)
         `CHK(code_addr_o, w ? {port_two_high_address_i, index_reg_i} : 16'hbeef)
      end
      for (w = 0; w < 24; w++) begin
         @(posedge clock_i);
         {iram_addr_i, iram_indirect_i, bit_addr_i} <= $random(seed);
         #1 `CHK(iram_sfr_sel_o, iram_addr_i[7] & ~iram_indirect_i)
         n = iram_addr_i < 8'h20 ? 0 : iram_addr_i < 8'h30 ? 1 : iram_addr_i < 8'h80 ? 2 : 3;
         `CHK(iram_region_o, n[1:0])
         `CHK(iram_bank_o, iram_addr_i[2:0])
         `CHK(bit_index_o, bit_addr_i[2:0])
         `CHK(bit_byte_addr_o, bit_addr_i[7] ? {bit_addr_i[7:3], 3'h0} : 8'h20 + bit_addr_i[6:3])
      end
      @(posedge clock_i);
      {reset_i, boot_select_pin_i} <= 2'h3;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      sfr_rd(8'hff, 8'h41);
      `CHK(flash_in_data_o, 1'b1)
      $display("second reset done");
      stop_test;
   end
   initial begin
      #200000;
      miscompares++;
      stop_test;
   end
endmodule
